// ---- tb_tlim_ctrl.sv ----
// self-checking bench for the two-level interrupt masking block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   err_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module tb_tlim_ctrl;
   import tlim_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic err;
   logic core_ack;
   logic irq;
   logic [NSRC-1:0] srcv = '0;
   logic [NSRC-1:0] lvl;
   logic [NSRC-1:0] en;
   logic [1:0] dly = 2'h0;
   logic [1:0] cc [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic [7:0] offs [8] = '{OFF_LSEL_A, OFF_LSEL_B, OFF_LSEL_C, OFF_LSEL_D,
      OFF_ENABLE, OFF_CCR, OFF_STATUS, OFF_IMASK};
   logic [31:0] rstv [8] = '{32'(LSEL_RST), 32'(LSEL_RST), 32'(LSEL_RST),
      32'(LSEL_RST), 32'(ENABLE_RST), 32'(CCR_RST), 32'(STAT_RST), 32'h0};
   tlim_core_type core_out;
   logic [3:0] offq [$];
   logic [3:0] expq [$];
   int err_count = 0;
   int num_checks = 0;
   integer seed = 32'h0104;

   // ----------------------------------------------------------------
   // clock, design and core model
   // ----------------------------------------------------------------
   always #2 pclk = ~pclk;
   tlim_ctrl uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nmi_pin(srcv[SRC_NMI]),
      .external_line({srcv[SRC_EXT3], srcv[SRC_EXT2], srcv[SRC_EXT1],
         srcv[SRC_EXT0]}),
      .event_input_irq(srcv[SRC_EVENT]), .key_input_irq(srcv[SRC_KEY]),
      .wakeup_event_irq(srcv[SRC_WAKE]), .address_break(srcv[SRC_ABRK]),
      .periph_req({srcv[SRC_PER1], srcv[SRC_PER0]}), .core_out(core_out),
      .core_ack(core_ack), .irq(irq));
   tlim_core_model core (.pclk(pclk), .presetn(presetn),
      .core_out(core_out), .delay(dly), .core_ack(core_ack));
   // log of every offer the core took
   always @(posedge pclk) begin
      if (core_ack === 1'b1 && core_out.valid === 1'b1) offq.push_back(core_out.src);
   end

   // ----------------------------------------------------------------
   // tasks and expectations
   // ----------------------------------------------------------------
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // one apb transfer, held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task pulse(input logic [NSRC-1:0] m);
      @(posedge pclk);
      srcv <= m;
      @(posedge pclk);
      srcv <= '0;
   endtask : pulse
   function automatic logic acc(int s, logic [1:0] c, logic [NSRC-1:0] lv);
      if (s == SRC_NMI || s == SRC_ABRK) return 1'b1;
      if (s == SRC_EVENT || s == SRC_KEY || s == SRC_WAKE) return !c[0];
      return lv[s] ? !(c[0] && c[1]) : !c[0];
   endfunction : acc

   // watchdog well beyond the expected run
   initial begin
      #160000;
      err_count++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then unmapped and misaligned places
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 32'h0);
         `CHK(rd, rstv[i])
      end
      apb(1'b0, 8'h24, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b0, 8'h02, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, OFF_ENABLE, 32'h0000_07FF);
      // every source against every mask state, two level layouts
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, OFF_LSEL_A, k ? 32'h0000_00C0 : 32'h0000_0020);
         apb(1'b1, OFF_LSEL_B, k ? 32'h0000_00C0 : 32'h0000_0000);
         lvl = k ? 11'h618 : 11'h006;
         foreach (cc[i]) for (int s = 0; s < NSRC; s++) begin
            dly <= 2'($random(seed));
            apb(1'b1, OFF_CCR, {30'h0, cc[i]});
            offq.delete();
            pulse(11'h1 << s);
            repeat (15) @(posedge pclk);
            `CHK(offq.size(), acc(s, cc[i], lvl) ? 1 : 0)
            if (!acc(s, cc[i], lvl)) begin
               apb(1'b1, OFF_CCR, 32'h0);
               repeat (15) @(posedge pclk);
            end
            `CHK(offq.size(), 1)
            if (offq.size() > 0) `CHK(offq[0], 4'(s))
         end
      end
      // offer withdrawn when both masks rise before the core takes it
      offq.delete();
      fork
         pulse(11'h1 << SRC_PER0);
         apb(1'b1, OFF_CCR, 32'h3);
      join
      repeat (10) @(posedge pclk);
      `CHK(offq.size(), 0)
      apb(1'b0, OFF_STATE, 32'h0);
      `CHK(rd, (32'h1 << (7 + SRC_PER0)) | (32'(SRC_PER0) << 3))
      apb(1'b1, OFF_CCR, 32'h0);
      repeat (15) @(posedge pclk);
      `CHK(offq.size(), 1)
      if (offq.size() > 0) `CHK(offq[0], 4'(SRC_PER0))
      // held and taken events through the interrupt output
      apb(1'b1, OFF_CCR, 32'h3);
      apb(1'b1, OFF_STATUS, 32'h3);
      apb(1'b1, OFF_IMASK, 32'h2);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK({irq, rd}, {1'b0, 32'h0})
      pulse(11'h1 << SRC_EXT0);
      repeat (8) @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(1'b1, OFF_IMASK, 32'h1);
      @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b1, OFF_CCR, 32'h0);
      repeat (15) @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(1'b1, OFF_STATUS, 32'h3);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK({irq, rd}, {1'b0, 32'h0})
      // all maskable sources at once, all enabled then three random enable sets
      for (int k = 0; k < 4; k++) begin
         en = k ? 11'($random(seed)) : 11'h7FF;
         dly <= 2'($random(seed));
         apb(1'b1, OFF_CCR, 32'h3);
         apb(1'b1, OFF_ENABLE, {21'h0, en});
         offq.delete();
         pulse(11'h7DE);
         repeat (10) @(posedge pclk);
         `CHK(offq.size(), 0)
         apb(1'b1, OFF_CCR, 32'h0);
         repeat (100) @(posedge pclk);
         expq.delete();
         for (int s = 1; s < NSRC; s++) begin
            if (en[s] && s != SRC_ABRK) expq.push_back(4'(s));
         end
         `CHK(offq.size(), expq.size())
         foreach (expq[i]) if (i < offq.size()) `CHK(offq[i], expq[i])
      end
      stop_test();
   end
endmodule : tb_tlim_ctrl
`default_nettype wire

// ---- tlim_core_model.sv ----
// processor core model that takes interrupt offers after a set delay
`timescale 1ns/1ps
`default_nettype none
module tlim_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire tlim_pkg::tlim_core_type core_out,
   input wire logic [1:0] delay,
   output logic core_ack
);
   import tlim_pkg::*;
   logic [1:0] wait_cnt;
   // one ack pulse once an offer has stood for delay cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_ack <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (core_ack || !core_out.valid) begin
         core_ack <= 1'b0; // withdrawn offer restarts the wait
         wait_cnt <= 2'h0;
      end else if (wait_cnt == delay) begin
         core_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule : tlim_core_model
`default_nettype wire

// ---- tlim_ctrl.sv ----
// two-level interrupt masking controller with apb registers
// What this block does
// - masks peripheral and line requests by global, user mask and level
// - level 0 requests pass when global mask clear, else stay pending
// - event, key and wake-up requests follow the global mask only
// - level 1 requests pass unless both mask bits are set
// - non-maskable and address-break requests always pass
// - service order: nmi, line 2, 3, 0, 1, then address break
// - level select 20,00,00,00 puts lines 2 and 3 at level 1
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tlim_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi_pin,
   input wire logic [3:0] external_line,
   input wire logic event_input_irq,
   input wire logic key_input_irq,
   input wire logic wakeup_event_irq,
   input wire logic address_break,
   input wire logic [tlim_pkg::NPER-1:0] periph_req,
   output tlim_pkg::tlim_core_type core_out,
   input wire logic core_ack,
   output logic irq
);
   import tlim_pkg::*;

   logic [7:0] lsel [0:3];
   logic [NSRC-1:0] enable;
   logic [1:0] cond_code_reg;
   logic [1:0] status;
   logic [1:0] imask;
   logic [NPIN-1:0] pin_sync;
   logic [NSRC-1:0] raw;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] lvl;
   logic [NSRC-1:0] accept;
   logic [NSRC-1:0] maskable;
   logic pick_any;
   logic [3:0] pick_idx;
   tlim_state_type state;
   logic gmask;
   logic umask;
   logic ok0;
   logic ok1;
   logic setup_cyc;
   logic wr_take;
   logic [3:0] wsel;
   logic take_ack;
   logic held_evt;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   function automatic logic [3:0] tlim_sel(input logic [7:0] a);
      logic [3:0] s;
      case (a)
         OFF_LSEL_A: s = 4'h0;
         OFF_LSEL_B: s = 4'h1;
         OFF_LSEL_C: s = 4'h2;
         OFF_LSEL_D: s = 4'h3;
         OFF_ENABLE: s = 4'h4;
         OFF_CCR: s = 4'h5;
         OFF_STATUS: s = 4'h6;
         OFF_IMASK: s = 4'h7;
         OFF_STATE: s = 4'h8;
         default: s = 4'hF;
      endcase
      return s;
   endfunction : tlim_sel

   // ----------------------------------------------------------------
   // input capture
   // ----------------------------------------------------------------
   tlim_sync #(.W(NPIN)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin({wakeup_event_irq, key_input_irq, event_input_irq,
            external_line, nmi_pin}),
      .sync(pin_sync)
   );

   // source vector in service order
   always_comb begin
      raw = '0;
      raw[SRC_NMI] = pin_sync[0];
      raw[SRC_EXT0] = pin_sync[1];
      raw[SRC_EXT1] = pin_sync[2];
      raw[SRC_EXT2] = pin_sync[3];
      raw[SRC_EXT3] = pin_sync[4];
      raw[SRC_EVENT] = pin_sync[5];
      raw[SRC_KEY] = pin_sync[6];
      raw[SRC_WAKE] = pin_sync[7];
      raw[SRC_ABRK] = address_break;
      raw[SRC_PER0] = periph_req[0];
      raw[SRC_PER1] = periph_req[1];
   end

   // ----------------------------------------------------------------
   // level and mask evaluation
   // ----------------------------------------------------------------
   assign gmask = cond_code_reg[CCR_GMASK];
   assign umask = cond_code_reg[CCR_UMASK];
   assign ok0 = !gmask;
   assign ok1 = !gmask || !umask;

   // control level of each source from the level selects
   always_comb begin
      lvl = '0;
      lvl[SRC_EXT0] = lsel[0][LVL_EXT0_BIT];
      lvl[SRC_EXT1] = lsel[0][LVL_EXT1_BIT];
      lvl[SRC_EXT2] = lsel[0][LVL_EXT23_BIT];
      lvl[SRC_EXT3] = lsel[0][LVL_EXT23_BIT];
      lvl[SRC_PER0] = lsel[1][LVL_PER0_BIT];
      lvl[SRC_PER1] = lsel[1][LVL_PER1_BIT];
   end

   // nmi and address break bypass every mask
   always_comb begin
      maskable = '1;
      maskable[SRC_NMI] = 1'b0;
      maskable[SRC_ABRK] = 1'b0;
   end

   // accept per source
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : g_acc
         if (g == SRC_EVENT || g == SRC_KEY || g == SRC_WAKE) begin : g_gm
            assign accept[g] = pend[g] && enable[g] && ok0;
         end else begin : g_lv
            assign accept[g] = pend[g] && (!maskable[g] ||
               (enable[g] && (lvl[g] ? ok1 : ok0)));
         end
      end
   endgenerate

   tlim_prio #(.W(NSRC)) u_prio (
      .req(accept),
      .any(pick_any),
      .idx(pick_idx)
   );

   // ----------------------------------------------------------------
   // pending flags, held until the core takes them
   // ----------------------------------------------------------------
   assign take_ack = core_ack && state == TLIM_OFFER;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= '0;
      end else begin
         for (int i = 0; i < NSRC; i++) begin
            if (raw[i]) begin
               pend[i] <= 1'b1;
            end else if (take_ack && core_out.src == 4'(i)) begin
               pend[i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // offer to the core
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= TLIM_IDLE;
         core_out <= '0;
      end else begin
         case (state)
            TLIM_IDLE: begin
               if (pick_any) begin
                  state <= TLIM_OFFER;
                  core_out.valid <= 1'b1;
                  core_out.src <= pick_idx;
               end
            end
            TLIM_OFFER: begin
               if (take_ack) begin
                  state <= TLIM_DONE;
                  core_out.valid <= 1'b0;
               end else if (!accept[core_out.src]) begin
                  state <= TLIM_IDLE;
                  core_out.valid <= 1'b0;
               end
            end
            TLIM_DONE: begin
               state <= TLIM_IDLE;
            end
            default: begin
               state <= TLIM_IDLE;
               core_out.valid <= 1'b0;
            end
         endcase
      end
   end

   // a maskable request waits behind the masks
   assign held_evt = |(pend & maskable & ~accept & enable);

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign setup_cyc = psel && !penable;
   assign wr_take = psel && penable && pwrite && !pslverr;
   assign wsel = tlim_sel(paddr);

   // error flag and read data set up in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (setup_cyc) begin
         pslverr <= (wsel == 4'hF) || (paddr[1:0] != 2'b00);
         case (wsel)
            4'h0, 4'h1, 4'h2, 4'h3: prdata <= {24'h00_0000, lsel[wsel[1:0]]};
            4'h4: prdata <= {21'h00_0000, enable};
            4'h5: prdata <= {30'h0000_0000, cond_code_reg};
            4'h6: prdata <= {30'h0000_0000, status};
            4'h7: prdata <= {30'h0000_0000, imask};
            4'h8: prdata <= {14'h0000, pend, core_out.src, state,
                             core_out.valid};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // configuration writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            lsel[i] <= LSEL_RST;
         end
         enable <= ENABLE_RST;
         cond_code_reg <= CCR_RST;
         imask <= STAT_RST;
      end else if (wr_take) begin
         case (wsel)
            4'h0, 4'h1, 4'h2, 4'h3: lsel[wsel[1:0]] <= pwdata[7:0];
            4'h4: enable <= pwdata[NSRC-1:0];
            4'h5: cond_code_reg <= pwdata[1:0];
            4'h7: imask <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // sticky status, a set beats a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= STAT_RST;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == ST_TAKEN) ? take_ack : held_evt) begin
               status[i] <= 1'b1;
            end else if (wr_take && wsel == 4'h6 && pwdata[i]) begin
               status[i] <= 1'b0;
            end
         end
      end
   end

   // level interrupt
   assign irq = |(status & imask);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_lvl0_held;
      @(posedge pclk) disable iff (!presetn)
      (gmask && !lvl[SRC_EXT0] && pend[SRC_EXT0])
         |-> !accept[SRC_EXT0] ##1 pend[SRC_EXT0];
   endproperty
   a_lvl0_held: assert property (p_lvl0_held)
      else $error("level 0 request not held under global mask");

   property p_lvl1_drop;
      @(posedge pclk) disable iff (!presetn)
      (state == TLIM_OFFER && gmask && umask && !core_ack &&
         maskable[core_out.src]) |=> state == TLIM_IDLE;
   endproperty
   a_lvl1_drop: assert property (p_lvl1_drop)
      else $error("masked offer not withdrawn");

   property p_nmi_first;
      @(posedge pclk) disable iff (!presetn)
      (state == TLIM_IDLE && pend[SRC_NMI])
         |=> core_out.valid && core_out.src == 4'(SRC_NMI);
   endproperty
   a_nmi_first: assert property (p_nmi_first)
      else $error("nmi not offered next cycle");

   property p_gm_only;
      @(posedge pclk) disable iff (!presetn)
      (pend[SRC_KEY] && enable[SRC_KEY] && !gmask && umask)
         |-> accept[SRC_KEY];
   endproperty
   a_gm_only: assert property (p_gm_only)
      else $error("key request blocked by user mask");

   property p_order;
      @(posedge pclk) disable iff (!presetn)
      (state == TLIM_IDLE && accept[SRC_EXT2] && !accept[SRC_NMI])
         |=> core_out.src == 4'(SRC_EXT2);
   endproperty
   a_order: assert property (p_order)
      else $error("line 2 not served ahead of later sources");

   property p_enable;
      @(posedge pclk) disable iff (!presetn)
      (state == TLIM_IDLE && pick_any) |=> core_out.valid &&
         (!maskable[core_out.src] || $past(enable[pick_idx]));
   endproperty
   a_enable: assert property (p_enable)
      else $error("disabled source offered");

   property p_example;
      @(posedge pclk) disable iff (!presetn)
      (lsel[0] == 8'h20) |-> lvl[SRC_EXT2] && lvl[SRC_EXT3] &&
         !lvl[SRC_EXT0] && !lvl[SRC_EXT1] && !lvl[SRC_PER0];
   endproperty
   a_example: assert property (p_example)
      else $error("example level setting mapped wrongly");

   property p_three_state;
      @(posedge pclk) disable iff (!presetn)
      (gmask && !umask && pend[SRC_EXT3] && enable[SRC_EXT3] &&
         lvl[SRC_EXT3]) |-> accept[SRC_EXT3] && (accept[SRC_PER1] ==
         (pend[SRC_PER1] && enable[SRC_PER1] && lvl[SRC_PER1]));
   endproperty
   a_three_state: assert property (p_three_state)
      else $error("middle mask state wrong");

endmodule : tlim_ctrl
`default_nettype wire

// ---- tlim_pkg.sv ----
// shared constants and types for the two-level interrupt masking block
package tlim_pkg;
   // ----------------------------------------------------------------
   // sources, in service order (lowest index served first)
   // ----------------------------------------------------------------
   localparam int NSRC = 11;
   localparam int SRC_NMI = 0;
   localparam int SRC_EXT2 = 1;
   localparam int SRC_EXT3 = 2;
   localparam int SRC_EXT0 = 3;
   localparam int SRC_EXT1 = 4;
   localparam int SRC_ABRK = 5;
   localparam int SRC_EVENT = 6;
   localparam int SRC_KEY = 7;
   localparam int SRC_WAKE = 8;
   localparam int SRC_PER0 = 9;
   localparam int SRC_PER1 = 10;
   localparam int NPIN = 8;
   localparam int NPER = 2;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_LSEL_A = 8'h00;
   localparam logic [7:0] OFF_LSEL_B = 8'h04;
   localparam logic [7:0] OFF_LSEL_C = 8'h08;
   localparam logic [7:0] OFF_LSEL_D = 8'h0C;
   localparam logic [7:0] OFF_ENABLE = 8'h10;
   localparam logic [7:0] OFF_CCR = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_IMASK = 8'h1C;
   localparam logic [7:0] OFF_STATE = 8'h20;
   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int LVL_EXT0_BIT = 7;
   localparam int LVL_EXT1_BIT = 6;
   localparam int LVL_EXT23_BIT = 5;
   localparam int LVL_PER0_BIT = 7;
   localparam int LVL_PER1_BIT = 6;
   localparam int CCR_GMASK = 0;
   localparam int CCR_UMASK = 1;
   localparam int ST_TAKEN = 0;
   localparam int ST_HELD = 1;
   localparam logic [7:0] LSEL_RST = 8'h00;
   localparam logic [NSRC-1:0] ENABLE_RST = 11'h000;
   localparam logic [1:0] CCR_RST = 2'h1;
   localparam logic [1:0] STAT_RST = 2'h0;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TLIM_IDLE = 2'b00,
      TLIM_OFFER = 2'b01,
      TLIM_DONE = 2'b11
   } tlim_state_type;
   typedef struct packed {
      logic valid;
      logic [3:0] src;
   } tlim_core_type;
endpackage : tlim_pkg

// ---- tlim_prio.sv ----
// fixed priority pick, lowest index wins
`timescale 1ns/1ps
`default_nettype none
module tlim_prio #(
   parameter int W = 11
) (
   input wire logic [W-1:0] req,
   output logic any,
   output logic [3:0] idx
);
   // ----------------------------------------------------------------
   // scan from the bottom, first hit is kept
   // ----------------------------------------------------------------
   always_comb begin
      any = 1'b0;
      idx = 4'h0;
      for (int i = 0; i < W; i++) begin
         if (req[i] && !any) begin
            any = 1'b1;
            idx = 4'(i);
         end
      end
   end
endmodule : tlim_prio
`default_nettype wire

// ---- tlim_sync.sv ----
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module tlim_sync #(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] sync
);
   logic [W-1:0] meta;
   // ----------------------------------------------------------------
   // one pair of flops per bit
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta[g] <= 1'b0;
               sync[g] <= 1'b0;
            end else begin
               meta[g] <= pin[g];
               sync[g] <= meta[g];
            end
         end
      end
   endgenerate
endmodule : tlim_sync
`default_nettype wire
